// File: logic/eptr_pkg.sv
package eptr_pkg;
  // register offsets on the serial control port (byte addresses)
  localparam logic [7:0] EMPH_OFFS = 8'h77;
  localparam logic [7:0] TXADJ_OFFS = 8'h78;
  localparam logic [7:0] RXADJ_OFFS = 8'h79;
  // hardware defaults, used when no factory value is present
  localparam logic [7:0] EMPH_RST = 8'h00;
  localparam logic [7:0] TXADJ_RST = 8'h0b;
  localparam logic [7:0] RXADJ_RST = 8'h60;
  // field positions
  localparam int EMPH_LVL_LSB = 5;
  localparam int EMPH_WID_LSB = 3;
  localparam int CHG_DET_BIT = 0;
  localparam int AUTORES_DIS_BIT = 6;
  localparam int EDGE_LSB = 3;
  localparam int SWING_LSB = 0;
  localparam int IDLE_LSB = 4;
  localparam int EQ_LSB = 0;
  // register count and index
  localparam int NREG = 3;
  localparam logic [1:0] IDX_EMPH = 2'h0;
  localparam logic [1:0] IDX_TXADJ = 2'h1;
  localparam logic [1:0] IDX_RXADJ = 2'h2;
  // charger detection sequence
  typedef enum logic [1:0] {
    EPTR_IDLE = 2'h0,
    EPTR_DETECT = 2'h1,
    EPTR_PULLUP = 2'h3
  } eptr_chg_t;
endpackage

// File: logic/eptr_reg_cell.sv
`timescale 1ns/1ns
// one byte register with factory-value load after reset release
module eptr_reg_cell (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [7:0] hw_default, // hardware default value
  input wire logic load_en, // one-cycle factory load strobe
  input wire logic otp_valid, // factory value present
  input wire logic [7:0] otp_value, // factory value
  input wire logic wr_en, // software write strobe
  input wire logic [7:0] wr_data, // software write data
  output logic [7:0] value // current register value
);
  logic [7:0] val_q;
  logic [7:0] val_d;
  logic seeded_q;
  logic seeded_d;

  // software write wins over the load strobe only after seeding
  always_comb
  begin
    val_d = val_q;
    seeded_d = seeded_q;
    if (load_en && !seeded_q)
    begin
      val_d = otp_valid ? otp_value : hw_default;
      seeded_d = 1'b1;
    end
    else if (wr_en)
    begin
      val_d = wr_data;
    end
  end

  // async reset takes constants only; default is re-applied at load
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      val_q <= 8'h00;
      seeded_q <= 1'b0;
    end
    else
    begin
      val_q <= val_d;
      seeded_q <= seeded_d;
    end
  end

  assign value = val_q;
endmodule

// File: logic/eptr_tuning_regs.sv
`timescale 1ns/1ns
// What this block does
// [R01] bits 7..5 of the emphasis register hold the pre-emphasis level, reset code 0 meaning none.
// [R02] bits 4..3 of the emphasis register hold the pre-emphasis width, reset code 0.
// [R03] bit 0 of the emphasis register enables charger detection in peripheral mode, reset 0.
// [R04] a detection attempt starts only with the enable set and a connect announced by the host processor.
// [R05] when a detection attempt finishes the upstream pull-up is switched on.
// [R06] bit 6 of the transmit adjust register disables auto-resume when one, reset 0.
// [R07] bits 4..3 of the transmit adjust register hold the edge rate, reset code 1.
// [R08] bits 2..0 of the transmit adjust register hold the swing code, reset code 3.
// [R09] bits 6..4 of the receive adjust register hold the idle threshold, reset code 6.
// [R10] bits 3..0 of the receive adjust register hold the equalizer level, reset code 0.
// [R11] emphasis at 77h, transmit adjust at 78h with reset 0bh, receive adjust at 79h.
// [R12] after reset each register loads its factory value when present, else its default.
// [R13] reads return the last written or loaded value, and writes reach the controls one cycle after the register updates.
module eptr_tuning_regs (
  input wire logic clk, // 25 MHz system clock
  input wire logic rst, // async reset, active high
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register byte offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic [2:0] otp_valid, // factory value present, per register
  input wire logic [23:0] otp_data, // factory values, register 0 in low byte
  input wire logic peripheral_mode, // repeater acting as peripheral
  input wire logic connect_announce, // host processor announced connect
  input wire logic detect_done, // charger detection attempt complete
  output logic [7:0] reg_rdata, // read data
  output logic reg_hit, // read addressed one of the registers
  output logic [2:0] tx_emphasis_level, // pre-emphasis level
  output logic [1:0] tx_emphasis_width, // pre-emphasis width
  output logic charger_detect_on, // charger detection enable bit
  output logic autoresume_off, // auto-resume disable
  output logic [1:0] tx_edge_speed, // transmit edge rate
  output logic [2:0] tx_swing_code, // transmit swing
  output logic [2:0] rx_idle_threshold, // receive idle threshold
  output logic [3:0] rx_equalizer_level, // receive equalizer
  output logic detect_run, // charger detection attempt running
  output logic pullup_on // upstream pull-up enable
);
  logic [7:0] regs [eptr_pkg::NREG];
  logic [7:0] defaults [eptr_pkg::NREG];
  logic [7:0] offsets [eptr_pkg::NREG];
  logic load_q;
  logic load_d;
  logic [7:0] rdata_d;
  logic hit_d;
  eptr_pkg::eptr_chg_t chg_q;
  eptr_pkg::eptr_chg_t chg_d;
  logic charger_en_w;
  logic run_d;
  logic pull_d;
  logic [2:0] level_d;
  logic [1:0] width_d;
  logic chg_on_d;
  logic resume_off_d;
  logic [1:0] edge_d;
  logic [2:0] swing_d;
  logic [2:0] idle_d;
  logic [3:0] eq_d;

  // per-register tables
  assign defaults[eptr_pkg::IDX_EMPH] = eptr_pkg::EMPH_RST; // R01 R02 R03
  assign defaults[eptr_pkg::IDX_TXADJ] = eptr_pkg::TXADJ_RST; // R06 R07 R08 R11
  assign defaults[eptr_pkg::IDX_RXADJ] = eptr_pkg::RXADJ_RST; // R09 R10
  assign offsets[eptr_pkg::IDX_EMPH] = eptr_pkg::EMPH_OFFS; // R11
  assign offsets[eptr_pkg::IDX_TXADJ] = eptr_pkg::TXADJ_OFFS; // R11
  assign offsets[eptr_pkg::IDX_RXADJ] = eptr_pkg::RXADJ_OFFS; // R11
  assign charger_en_w = regs[eptr_pkg::IDX_EMPH][eptr_pkg::CHG_DET_BIT]; // R03

  // factory load strobe fires once, first edge after reset release
  always_comb
  begin
    load_d = 1'b0;
  end

  // load_q is 1 out of reset and drops after one cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      load_q <= 1'b1;
    end
    else
    begin
      load_q <= load_d;
    end
  end

  // one cell per register; reserved bits stored too
  genvar gi;
  generate
    for (gi = 0; gi < eptr_pkg::NREG; gi++)
    begin : g_reg
      eptr_reg_cell u_cell (
        .clk(clk),
        .rst(rst),
        .hw_default(defaults[gi]),
        .load_en(load_q), // R12
        .otp_valid(otp_valid[gi]),
        .otp_value(otp_data[8*gi +: 8]),
        .wr_en(reg_wr && (reg_addr == offsets[gi])), // R13
        .wr_data(reg_wdata),
        .value(regs[gi])
      );
    end
  endgenerate

  // read mux; unmapped offsets read zero with hit low
  always_comb
  begin
    rdata_d = 8'h00;
    hit_d = 1'b0;
    for (int i = 0; i < eptr_pkg::NREG; i++)
    begin
      if (reg_rd && (reg_addr == offsets[i]))
      begin
        rdata_d = regs[i]; // R13
        hit_d = 1'b1;
      end
    end
  end

  // charger detection: gated by enable, peripheral mode and connect
  always_comb
  begin
    chg_d = chg_q;
    case (chg_q)
      eptr_pkg::EPTR_IDLE:
      begin
        if (charger_en_w && peripheral_mode && connect_announce)
        begin
          chg_d = eptr_pkg::EPTR_DETECT; // R04
        end
      end
      eptr_pkg::EPTR_DETECT:
      begin
        if (detect_done)
        begin
          chg_d = eptr_pkg::EPTR_PULLUP; // R05
        end
        else if (!charger_en_w)
        begin
          chg_d = eptr_pkg::EPTR_PULLUP; // R03
        end
      end
      eptr_pkg::EPTR_PULLUP:
      begin
        // pull-up held until the host withdraws the connect
        if (!connect_announce)
        begin
          chg_d = eptr_pkg::EPTR_IDLE;
        end
      end
      default:
      begin
        chg_d = eptr_pkg::EPTR_IDLE;
      end
    endcase
    // status outputs follow the next state, so they line up with chg_q
    run_d = (chg_d == eptr_pkg::EPTR_DETECT); // R04
    pull_d = (chg_d == eptr_pkg::EPTR_PULLUP); // R05
  end

  // read path: data and hit stand for one cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end
    else
    begin
      reg_rdata <= rdata_d; // R13
      reg_hit <= hit_d; // R11
    end
  end

  // detection state and its two status outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      chg_q <= eptr_pkg::EPTR_IDLE;
      detect_run <= 1'b0;
      pullup_on <= 1'b0;
    end
    else
    begin
      chg_q <= chg_d;
      detect_run <= run_d; // R04
      pullup_on <= pull_d; // R05
    end
  end

  // field next values; the extra stage keeps outputs on flops at the cost of one cycle
  always_comb
  begin
    level_d = regs[eptr_pkg::IDX_EMPH][eptr_pkg::EMPH_LVL_LSB +: 3]; // R01
    width_d = regs[eptr_pkg::IDX_EMPH][eptr_pkg::EMPH_WID_LSB +: 2]; // R02
    chg_on_d = charger_en_w; // R03
    resume_off_d = regs[eptr_pkg::IDX_TXADJ][eptr_pkg::AUTORES_DIS_BIT]; // R06
    edge_d = regs[eptr_pkg::IDX_TXADJ][eptr_pkg::EDGE_LSB +: 2]; // R07
    swing_d = regs[eptr_pkg::IDX_TXADJ][eptr_pkg::SWING_LSB +: 3]; // R08
    idle_d = regs[eptr_pkg::IDX_RXADJ][eptr_pkg::IDLE_LSB +: 3]; // R09
    eq_d = regs[eptr_pkg::IDX_RXADJ][eptr_pkg::EQ_LSB +: 4]; // R10
  end

  // field copies follow the cells one cycle late; zero in reset since cells are not seeded yet
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_emphasis_level <= 3'h0;
      tx_emphasis_width <= 2'h0;
      charger_detect_on <= 1'b0;
      autoresume_off <= 1'b0;
      tx_edge_speed <= 2'h0;
      tx_swing_code <= 3'h0;
      rx_idle_threshold <= 3'h0;
      rx_equalizer_level <= 4'h0;
    end
    else
    begin
      tx_emphasis_level <= level_d; // R01
      tx_emphasis_width <= width_d; // R02
      charger_detect_on <= chg_on_d; // R03
      autoresume_off <= resume_off_d; // R06
      tx_edge_speed <= edge_d; // R07
      tx_swing_code <= swing_d; // R08
      rx_idle_threshold <= idle_d; // R09
      rx_equalizer_level <= eq_d; // R10
    end
  end
endmodule

// File: tb/eptr_tuning_regs_sva.sv
`timescale 1ns/1ns
// bus and detection checks on the tuning bank ports
module eptr_tuning_regs_chk (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [7:0] reg_addr, // offset
  input wire logic [7:0] reg_wdata, // wdata
  input wire logic peripheral_mode, // mode
  input wire logic connect_announce, // connect
  input wire logic detect_done, // done
  input wire logic [7:0] reg_rdata, // rdata
  input wire logic reg_hit, // hit
  input wire logic [2:0] tx_emphasis_level, // level
  input wire logic [1:0] tx_emphasis_width, // width
  input wire logic charger_detect_on, // enable
  input wire logic autoresume_off, // resume off
  input wire logic [1:0] tx_edge_speed, // edge
  input wire logic [2:0] tx_swing_code, // swing
  input wire logic [2:0] rx_idle_threshold, // idle
  input wire logic [3:0] rx_equalizer_level, // eq
  input wire logic detect_run, // running
  input wire logic pullup_on // pull-up
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // offsets that belong to this bank
  wire logic hit = reg_addr inside {8'h77, 8'h78, 8'h79};
  rd_hit_a: assert property (reg_rd && hit |=> reg_hit)
    else $error("mapped read gave no hit");
  rd_miss_a: assert property (reg_rd && !hit |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read answered");
  emph_wr_a: assert property (reg_wr && reg_addr == 8'h77 |-> ##2
    {tx_emphasis_level, tx_emphasis_width, charger_detect_on} == {$past(reg_wdata[7:3], 2), $past(reg_wdata[0], 2)})
    else $error("emphasis fields wrong after write");
  tx_wr_a: assert property (reg_wr && reg_addr == 8'h78 |-> ##2
    {autoresume_off, tx_edge_speed, tx_swing_code} == {$past(reg_wdata[6], 2), $past(reg_wdata[4:0], 2)})
    else $error("transmit fields wrong after write");
  rx_wr_a: assert property (reg_wr && reg_addr == 8'h79 |-> ##2
    {rx_idle_threshold, rx_equalizer_level} == $past(reg_wdata[6:0], 2)) else $error("receive fields wrong");
  // a write one cycle back may still change the enable that the logic sees
  det_start_a: assert property (charger_detect_on && peripheral_mode && connect_announce && !detect_run
    && !pullup_on && !$past(reg_wr) |=> detect_run) else $error("detection did not start");
  det_cause_a: assert property ($rose(detect_run) |-> $past(peripheral_mode && connect_announce))
    else $error("detection started without connect");
  done_pull_a: assert property (detect_run && detect_done |=> pullup_on && !detect_run)
    else $error("pull-up not raised after detection");
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ns
// directed bench for the tuning register bank
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [2:0] otp_valid = 3'h0;
  logic [23:0] otp_data = 24'h000000;
  logic peripheral_mode = 1'b0;
  logic connect_announce = 1'b0;
  logic detect_done = 1'b0;
  logic [7:0] reg_rdata, v, t, r;
  logic [2:0] tx_emphasis_level, tx_swing_code, rx_idle_threshold;
  logic [1:0] tx_emphasis_width, tx_edge_speed;
  logic [3:0] rx_equalizer_level;
  logic reg_hit, charger_detect_on, autoresume_off, detect_run, pullup_on;
  int failures = 0;
  int checks = 0;
  always #20 clk = ~clk;
  eptr_tuning_regs dut (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .otp_valid, .otp_data,
    .peripheral_mode, .connect_announce, .detect_done, .reg_rdata, .reg_hit, .tx_emphasis_level,
    .tx_emphasis_width, .charger_detect_on, .autoresume_off, .tx_edge_speed, .tx_swing_code,
    .rx_idle_threshold, .rx_equalizer_level, .detect_run, .pullup_on);
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands one cycle only, so it is taken just after the edge
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", reg_rdata, e);
    chk("hit", {7'h0, reg_hit}, {7'h0, h});
  endtask
  // field outputs against stored bytes, reserved bits masked
  task automatic fld(input logic [7:0] e7, input logic [7:0] e8, input logic [7:0] e9);
    chk("f77", {tx_emphasis_level, tx_emphasis_width, 2'h0, charger_detect_on}, e7 & 8'hf9);
    chk("f78", {1'b0, autoresume_off, 1'b0, tx_edge_speed, tx_swing_code}, e8 & 8'h5f);
    chk("f79", {1'b0, rx_idle_threshold, rx_equalizer_level}, e9 & 8'h7f);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    do_reset();
    rdc(8'h77, 8'h00, 1'b1);
    rdc(8'h78, 8'h0b, 1'b1);
    rdc(8'h79, 8'h60, 1'b1);
    rdc(8'h7a, 8'h00, 1'b0);
    fld(8'h00, 8'h0b, 8'h60);
    $display("test defaults done");
    // every code of every field; reserved bits written too, emphasis bits 2..1 always 10
    for (int i = 0; i < 16; i++)
    begin
      v = {i[2:0], i[1:0], 2'h2, i[0]};
      t = {i[3], i[0], i[1], i[1:0], i[2:0]};
      r = {i[1], i[2:0], i[3:0]};
      wr(8'h77, v);
      wr(8'h78, t);
      wr(8'h79, r);
      wr(8'h7a, 8'hff);
      rdc(8'h77, v, 1'b1);
      rdc(8'h78, t, 1'b1);
      rdc(8'h79, r, 1'b1);
      fld(v, t, r);
    end
    $display("test codes done");
    otp_valid <= 3'h5;
    otp_data <= 24'h5a77c4;
    do_reset();
    rdc(8'h77, 8'hc4, 1'b1);
    rdc(8'h78, 8'h0b, 1'b1);
    rdc(8'h79, 8'h5a, 1'b1);
    $display("test factory load done");
    peripheral_mode <= 1'b1;
    connect_announce <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("run", {7'h0, detect_run}, 8'h00);
    wr(8'h77, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk("run", {7'h0, detect_run}, 8'h01);
    @(posedge clk);
    detect_done <= 1'b1;
    @(posedge clk);
    detect_done <= 1'b0;
    #1 chk("pull", {6'h0, pullup_on, detect_run}, 8'h02);
    @(posedge clk);
    connect_announce <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("pull", {7'h0, pullup_on}, 8'h00);
    // connect outside peripheral mode must not start, then mode starts it
    peripheral_mode <= 1'b0;
    connect_announce <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("run", {7'h0, detect_run}, 8'h00);
    peripheral_mode <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("run", {6'h0, pullup_on, detect_run}, 8'h01);
    // clearing the enable mid-attempt ends it and raises the pull-up
    wr(8'h77, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("pull", {6'h0, pullup_on, detect_run}, 8'h02);
    $display("test detection done");
    print_verdict();
  end
  // hang guard, far above the few hundred cycles the tests take
  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule
bind eptr_tuning_regs eptr_tuning_regs_chk chk_i (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .peripheral_mode, .connect_announce, .detect_done, .reg_rdata, .reg_hit, .tx_emphasis_level,
  .tx_emphasis_width, .charger_detect_on, .autoresume_off, .tx_edge_speed, .tx_swing_code,
  .rx_idle_threshold, .rx_equalizer_level, .detect_run, .pullup_on);
